/* File: src/ptsc_device.sv */
// Synthesizer end: serial control port, divider, pump, ports, IF counter.
// Assumes link and pin inputs are asynchronous to core_clk.
`timescale 1ns/1ns
module ptsc_device
	import ptsc_pkg::*;
#(
	parameter int TB_HALF_CYCLES = int'(TB_HALF_NS / CLK_NS),
	parameter int GATE_BASE_CYCLES = int'(GATE_BASE_NS / CLK_NS),
	parameter int REF_CYCLES = int'(REF_NS / CLK_NS)
)
(
	input wire logic core_clk,
	input wire logic reset_n,
	ptsc_link_if.device link,
	input wire logic vhf_osc_input,
	input wire logic hf_osc_input,
	input wire logic if_input,
	input wire logic [1:0] bidir_in,
	output logic [1:0] bidir_out,
	output logic [1:0] bidir_oe_n,
	output logic [3:0] od_oe_n,
	output logic pump_out_o,
	output logic pump_out_oe_n
);
	localparam int S_CLK = 0;
	localparam int S_EN = 1;
	localparam int S_DIN = 2;
	localparam int S_VHF = 3;
	localparam int S_HF = 4;
	localparam int S_IF = 5;
	localparam int S_IO = 6;
	localparam int NSYNC = 8;

	logic [NSYNC-1:0] sync_raw;
	logic [NSYNC-1:0] sync_a;
	logic [NSYNC-1:0] sync_b;
	logic [NSYNC-1:0] sync_c;
	logic [NSYNC-1:0] rise;
	logic [NSYNC-1:0] fall;
	logic [ADDR_BITS-1:0] addr_raw;
	logic [7:0] code;
	logic [WORD_BITS-1:0] shift_in;
	logic [4:0] bit_cnt;
	ptsc_kind_t mode;
	logic mode_valid;
	logic frame_ok;
	logic read_sel;
	logic [WORD_BITS-1:0] word_a;
	logic [WORD_BITS-1:0] word_b;
	logic pre_half;
	logic div_tick;
	logic [DIV_BITS-1:0] div_n;
	logic [DIV_BITS-1:0] div_cnt;
	logic div_pulse;
	logic [31:0] ref_cnt;
	logic ref_pulse;
	logic div_seen;
	logic div_more;
	logic div_many;
	logic unlocked;
	logic [31:0] tb_cnt;
	logic tb_level;
	logic [31:0] gate_cnt;
	logic [31:0] gate_len;
	logic gate_end;
	logic [IF_BITS-1:0] if_cnt;
	logic [IF_BITS-1:0] if_result;
	logic count_done;
	logic read_active;
	logic [READ_BITS-1:0] read_shift;
	logic ser_low;

	assign sync_raw = {bidir_in, if_input, hf_osc_input, vhf_osc_input,
		link.ser_in, link.xfer_enable, link.ser_clk};
	assign rise = sync_b & ~sync_c;
	assign fall = ~sync_b & sync_c;
	assign code = ptsc_swap_nibbles(addr_raw);
	assign read_sel = rise[S_EN] && code == ADDR_READ;
	assign frame_ok = fall[S_EN] && mode_valid && bit_cnt == 5'(WORD_BITS);
	assign unlocked = ~pump_out_oe_n;
	// Two or more divided pulses in the closing period
	assign div_many = div_more || (div_seen && div_pulse);

	// Two-stage synchronisers, third stage only for edge detection
	always_ff @(posedge core_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			sync_a <= '0;
			sync_b <= '0;
			sync_c <= '0;
		end
		else
		begin
			sync_a <= sync_raw;
			sync_b <= sync_a;
			sync_c <= sync_b;
		end
	end

	always_ff @(posedge core_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			addr_raw <= '0;
			shift_in <= '0;
			bit_cnt <= '0;
			mode <= KIND_WRITE_A;
			mode_valid <= 1'b0;
		end
		else if (rise[S_EN])
		begin
			bit_cnt <= '0;
			mode_valid <= 1'b1;
			if (code == ADDR_WRITE_A)
				mode <= KIND_WRITE_A;
			else if (code == ADDR_WRITE_B)
				mode <= KIND_WRITE_B;
			else if (code == ADDR_READ)
				mode <= KIND_READ;
			else
				mode_valid <= 1'b0;
		end
		else if (fall[S_EN])
			mode_valid <= 1'b0;
		else if (rise[S_CLK])
		begin
			if (!sync_b[S_EN])
				addr_raw <= {sync_b[S_DIN], addr_raw[ADDR_BITS-1:1]};
			else if (bit_cnt <= 5'(WORD_BITS))
			begin
				// count data bits, overrun spoils frame
				shift_in <= {sync_b[S_DIN], shift_in[WORD_BITS-1:1]};
				bit_cnt <= bit_cnt + 5'h1;
			end
		end
	end

	always_ff @(posedge core_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			word_a <= WORD_RESET;
			word_b <= WORD_RESET;
		end
		else if (frame_ok)
		begin
			if (mode == KIND_WRITE_A)
				word_a <= shift_in;
			if (mode == KIND_WRITE_B)
				word_b <= shift_in;
		end
	end

	assign div_tick = word_a[WA_BAND] ? (rise[S_VHF] && pre_half) : rise[S_HF];
	assign div_n = (word_a[WA_BAND] || word_a[WA_AM_RANGE]) ? word_a[DIV_BITS-1:0]
		: DIV_BITS'(word_a[DIV_BITS-1:DIRECT_LSB]);

	always_ff @(posedge core_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			pre_half <= 1'b0;
			div_cnt <= '0;
			div_pulse <= 1'b0;
		end
		else
		begin
			if (rise[S_VHF])
				pre_half <= ~pre_half;
			div_pulse <= 1'b0;
			if (div_tick)
			begin
				if (div_cnt <= DIV_BITS'(1))
				begin
					div_cnt <= div_n;
					div_pulse <= 1'b1;
				end
				else
					div_cnt <= div_cnt - DIV_BITS'(1);
			end
		end
	end

	always_ff @(posedge core_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			ref_cnt <= '0;
			ref_pulse <= 1'b0;
			div_seen <= 1'b0;
			div_more <= 1'b0;
			pump_out_o <= 1'b0;
			pump_out_oe_n <= 1'b1;
		end
		else
		begin
			ref_pulse <= ref_cnt == 32'(REF_CYCLES - 1);
			ref_cnt <= (ref_cnt == 32'(REF_CYCLES - 1)) ? '0 : ref_cnt + 32'h1;
			if (ref_pulse)
			begin
				// Verdict: none low, one released, more stays high
				div_seen <= 1'b0;
				div_more <= 1'b0;
				pump_out_o <= div_many;
				pump_out_oe_n <= (div_seen || div_pulse) && !div_many;
			end
			else if (div_pulse)
			begin
				div_seen <= 1'b1;
				if (div_seen)
				begin
					div_more <= 1'b1;
					pump_out_o <= 1'b1;
					pump_out_oe_n <= 1'b0;
				end
			end
		end
	end

	always_ff @(posedge core_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			tb_cnt <= '0;
			tb_level <= 1'b0;
		end
		else if (!word_b[WB_TB])
		begin
			tb_cnt <= '0;
			tb_level <= 1'b0;
		end
		else if (tb_cnt == 32'(TB_HALF_CYCLES - 1))
		begin
			tb_cnt <= '0;
			tb_level <= ~tb_level;
		end
		else
			tb_cnt <= tb_cnt + 32'h1;
	end

	// gate of 4, 8, 16 or 32 ms
	assign gate_len = 32'(GATE_BASE_CYCLES) << word_b[WB_GATE +: 2];
	assign gate_end = word_a[WA_IF_EN] && gate_cnt >= gate_len - 32'h1;

	always_ff @(posedge core_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			gate_cnt <= '0;
			if_cnt <= '0;
			if_result <= '0;
			count_done <= 1'b0;
		end
		else
		begin
			if (!word_a[WA_IF_EN])
			begin
				gate_cnt <= '0;
				if_cnt <= '0;
			end
			else if (gate_end)
			begin
				gate_cnt <= '0;
				if_cnt <= '0;
				if_result <= if_cnt + IF_BITS'(rise[S_IF]);
			end
			else
			begin
				gate_cnt <= gate_cnt + 32'h1;
				if_cnt <= if_cnt + IF_BITS'(rise[S_IF]);
			end
			if (gate_end)
				count_done <= 1'b1;
			else if (read_sel)
				count_done <= 1'b0;
		end
	end

	// one read bit per ser_clk cycle
	always_ff @(posedge core_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			read_active <= 1'b0;
			read_shift <= '0;
		end
		else if (read_sel)
		begin
			read_active <= 1'b1;
			read_shift <= {sync_b[S_IO+1], sync_b[S_IO], ~unlocked, if_result};
		end
		else if (fall[S_EN])
			read_active <= 1'b0;
		else if (read_active && fall[S_CLK])
			read_shift <= {read_shift[READ_BITS-2:0], 1'b0};
	end

	always_comb
	begin
		ser_low = 1'b0;
		if (read_active)
			ser_low = ~read_shift[READ_BITS-1];
		else
		begin
			unique case (word_b[WB_MUX +: 3])
				MUX_UNLOCK: ser_low = unlocked;
				MUX_END_COUNT: ser_low = count_done;
				MUX_BIDIR_1: ser_low = ~sync_b[S_IO];
				MUX_BIDIR_2: ser_low = ~sync_b[S_IO+1];
				default: ser_low = 1'b0;
			endcase
		end
	end

	always_ff @(posedge core_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			link.ser_out_oe_n <= 1'b1;
			od_oe_n <= '1;
			bidir_oe_n <= '1;
			bidir_out <= '0;
		end
		else
		begin
			link.ser_out_oe_n <= ~ser_low;
			od_oe_n <= ~{word_b[WB_OD+1 +: 3], word_b[WB_TB] ? tb_level : word_b[WB_OD]};
			bidir_oe_n <= ~(word_b[WB_DIR +: 2] & word_b[WB_BIDIR +: 2]);
			bidir_out <= '0;
		end
	end
endmodule

/* File: src/ptsc_pkg.sv */
// Shared constants and types for the tuner synthesizer serial control.
// Assumes a 100 MHz core clock at both ends of the three-wire link.
package ptsc_pkg;
	localparam longint CLK_NS = 10;
	localparam longint SER_HALF_NS = 1000;
	localparam longint REF_NS = 40000;
	localparam longint GATE_BASE_NS = 4000000;
	localparam longint TB_HALF_NS = 62500000;

	localparam logic [7:0] ADDR_WRITE_A = 8'h82;
	localparam logic [7:0] ADDR_WRITE_B = 8'h92;
	localparam logic [7:0] ADDR_READ = 8'ha2;
	localparam int ADDR_BITS = 8;
	localparam int WORD_BITS = 24;
	localparam int IF_BITS = 20;
	localparam int READ_BITS = 23;
	localparam logic [23:0] WORD_RESET = 24'h000000;

	localparam int DIV_BITS = 16;
	localparam int DIRECT_LSB = 4;
	localparam int WA_AM_RANGE = 16;
	localparam int WA_BAND = 17;
	localparam int WA_IF_EN = 18;
	localparam int WB_DIR = 0;
	localparam int WB_OD = 2;
	localparam int WB_BIDIR = 6;
	localparam int WB_MUX = 8;
	localparam int WB_TB = 11;
	localparam int WB_GATE = 12;

	localparam logic [3:0] REG_WDATA = 4'h0;
	localparam logic [3:0] REG_CMD = 4'h4;
	localparam logic [3:0] REG_STATUS = 4'h8;
	localparam logic [3:0] REG_RDATA = 4'hc;
	localparam int CMD_KIND_LSB = 0;
	localparam int CMD_COUNT_LSB = 8;
	localparam int CMD_COUNT_W = 5;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [2:0] {
		MUX_OPEN = 3'h0,
		MUX_UNLOCK = 3'h1,
		MUX_END_COUNT = 3'h2,
		MUX_BIDIR_1 = 3'h4,
		MUX_BIDIR_2 = 3'h5
	} ptsc_mux_t;

	typedef enum logic [1:0] {
		KIND_WRITE_A = 2'h0,
		KIND_WRITE_B = 2'h1,
		KIND_READ = 2'h2
	} ptsc_kind_t;

	typedef enum logic [2:0] {
		C_IDLE = 3'h0,
		C_ADDR = 3'h1,
		C_EN_UP = 3'h3,
		C_DATA = 3'h2,
		C_EN_DN = 3'h6
	} ptsc_cstate_t;

	// Wire order of an address byte is the code with nibbles swapped
	function automatic logic [7:0] ptsc_swap_nibbles(input logic [7:0] v);
		return {v[3:0], v[7:4]};
	endfunction
endpackage

/* File: src/ptsc_link_if.sv */
// Three-wire serial link between controller and synthesizer.
// Assumes a pull-up on the open-drain serial output line.
`timescale 1ns/1ns
interface ptsc_link_if;
	logic ser_clk;
	logic xfer_enable;
	logic ser_in;
	logic ser_out_oe_n;
	logic ser_out_line;

	// Released line reads high through the pull-up
	assign ser_out_line = ser_out_oe_n;

	modport device(input ser_clk, input xfer_enable, input ser_in, output ser_out_oe_n);
	modport controller(output ser_clk, output xfer_enable, output ser_in, input ser_out_line);
endinterface

/* File: src/ptsc_controller.sv */
// Controller end: AXI4-Lite registers drive three-wire link transfers.
// Assumes the device answers within a quarter of a ser_clk period.
`timescale 1ns/1ns
module ptsc_controller
	import ptsc_pkg::*;
#(
	parameter int SER_HALF_CYCLES = int'(SER_HALF_NS / CLK_NS)
)
(
	input wire logic core_clk,
	input wire logic reset_n,
	ptsc_link_if.controller link,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [3:0] s_axi_awaddr,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	output logic [1:0] s_axi_bresp,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	input wire logic [3:0] s_axi_araddr,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp
);
	ptsc_cstate_t state;
	logic [3:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	logic wr_go;
	logic start;
	logic [1:0] cmd_kind;
	logic [7:0] addr_code;
	logic [7:0] addr_wire;
	logic [WORD_BITS-1:0] wdata_reg;
	logic [READ_BITS-1:0] rx;
	logic [READ_BITS-1:0] rdata_reg;
	logic [1:0] kind;
	logic [CMD_COUNT_W-1:0] rd_count;
	logic [31:0] out_shift;
	logic [5:0] bits_left;
	logic [15:0] half_cnt;
	logic tick;
	logic [1:0] line_sync;

	assign wr_go = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
	assign cmd_kind = w_data[CMD_KIND_LSB +: 2];
	assign start = wr_go && aw_addr == REG_CMD && w_strb[0] && state == C_IDLE
		&& cmd_kind != 2'h3;
	assign addr_code = (cmd_kind == KIND_WRITE_A) ? ADDR_WRITE_A
		: (cmd_kind == KIND_WRITE_B) ? ADDR_WRITE_B : ADDR_READ;
	assign addr_wire = ptsc_swap_nibbles(addr_code);
	assign tick = half_cnt == 16'(SER_HALF_CYCLES - 1);

	always_ff @(posedge core_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
			aw_addr <= '0;
			w_data <= '0;
			w_strb <= '0;
			wdata_reg <= '0;
		end
		else
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				s_axi_awready <= 1'b0;
				aw_addr <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				s_axi_wready <= 1'b0;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end
			if (wr_go)
			begin
				s_axi_bvalid <= 1'b1;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
				s_axi_bresp <= (aw_addr[3:2] == 2'h3 || aw_addr[1:0] != 2'h0 || aw_addr
					== REG_RDATA) ? RESP_SLVERR : RESP_OKAY;
				if (aw_addr == REG_WDATA)
				begin
					for (int b = 0; b < WORD_BITS / 8; b++)
					begin
						if (w_strb[b])
							wdata_reg[8*b +: 8] <= w_data[8*b +: 8];
					end
				end
			end
			else if (s_axi_bvalid && s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end

	always_ff @(posedge core_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= '0;
			s_axi_rresp <= RESP_OKAY;
		end
		else if (s_axi_arvalid && s_axi_arready)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= RESP_OKAY;
			unique case (s_axi_araddr)
				REG_WDATA: s_axi_rdata <= 32'(wdata_reg);
				REG_CMD: s_axi_rdata <= 32'({rd_count, 6'h0, kind});
				REG_STATUS: s_axi_rdata <= 32'(state != C_IDLE);
				REG_RDATA: s_axi_rdata <= 32'(rdata_reg);
				default:
				begin
					s_axi_rdata <= '0;
					s_axi_rresp <= RESP_SLVERR;
				end
			endcase
		end
		else if (s_axi_rvalid && s_axi_rready)
		begin
			s_axi_rvalid <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

	// Read line passes two flops before sampling
	always_ff @(posedge core_clk or negedge reset_n)
	begin
		if (!reset_n)
			line_sync <= 2'h3;
		else
			line_sync <= {line_sync[0], link.ser_out_line};
	end

	always_ff @(posedge core_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			state <= C_IDLE;
			half_cnt <= '0;
			link.ser_clk <= 1'b0;
			link.xfer_enable <= 1'b0;
			link.ser_in <= 1'b0;
			out_shift <= '0;
			bits_left <= '0;
			kind <= KIND_WRITE_A;
			rd_count <= '0;
			rx <= '0;
			rdata_reg <= '0;
		end
		else
		begin
			half_cnt <= (tick || state == C_IDLE) ? '0 : half_cnt + 16'h1;
			unique case (state)
				C_IDLE:
				begin
					if (start)
					begin
						// address first, B0 first on the wire
						kind <= cmd_kind;
						rd_count <= w_data[CMD_COUNT_LSB +: CMD_COUNT_W];
						out_shift <= {wdata_reg, addr_wire};
						link.ser_in <= addr_wire[0];
						bits_left <= 6'(ADDR_BITS);
						rx <= '0;
						state <= C_ADDR;
					end
				end
				C_ADDR, C_DATA:
				begin
					// clock low half then high half per bit
					if (tick && !link.ser_clk)
						link.ser_clk <= 1'b1;
					else if (tick)
					begin
						link.ser_clk <= 1'b0;
						out_shift <= out_shift >> 1;
						link.ser_in <= out_shift[1];
						bits_left <= bits_left - 6'h1;
						if (state == C_DATA && kind == KIND_READ)
							rx <= {rx[READ_BITS-2:0], line_sync[1]};
						if (bits_left == 6'h1)
							state <= (state == C_ADDR) ? C_EN_UP : C_EN_DN;
					end
				end
				C_EN_UP:
				begin
					if (tick)
					begin
						// enable high over the data phase
						link.xfer_enable <= 1'b1;
						// 24 bits or chosen read count
						bits_left <= (kind == KIND_READ) ? 6'(rd_count) : 6'(WORD_BITS);
						state <= (kind == KIND_READ && rd_count == '0) ? C_EN_DN : C_DATA;
					end
				end
				C_EN_DN:
				begin
					if (tick)
					begin
						link.xfer_enable <= 1'b0;
						if (kind == KIND_READ)
							rdata_reg <= rx;
						state <= C_IDLE;
					end
				end
				default: state <= C_IDLE;
			endcase
		end
	end
endmodule

/* File: tb/ptsc_link_properties.sv */
// Checker on the three-wire link between controller and synthesizer.
// Assumes it sits beside the interface and sees its signals as inputs.
`timescale 1ns/1ns
module ptsc_link_properties
(
	input wire logic core_clk,
	input wire logic reset_n,
	input wire logic ser_clk,
	input wire logic xfer_enable,
	input wire logic ser_in,
	input wire logic ser_out_oe_n,
	input wire logic ser_out_line
);
	logic clk_q;
	logic en_q;
	logic [7:0] addr_sh;
	logic [7:0] mode;
	logic [5:0] rises;
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!reset_n);
	// Frame decoder, first address bit lands lowest
	always_ff @(posedge core_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			clk_q <= 1'b0;
			en_q <= 1'b0;
			addr_sh <= 8'h00;
			mode <= 8'h00;
			rises <= 6'h00;
		end
		else
		begin
			clk_q <= ser_clk;
			en_q <= xfer_enable;
			if (ser_clk && !clk_q && !xfer_enable)
				addr_sh <= {ser_in, addr_sh[7:1]};
			if (xfer_enable && !en_q)
				mode <= addr_sh;
			if (xfer_enable != en_q)
				rises <= 6'h00;
			else if (ser_clk && !clk_q)
				rises <= rises + 6'h01;
		end
	end
	a_out_reset: assert property ($rose(reset_n) |-> ser_out_oe_n)
		else $error("output not released after reset");
	a_clk_high_min: assert property ($rose(ser_clk) |=> ser_clk [*8])
		else $error("link clock high too short");
	a_en_clk_low: assert property ($changed(xfer_enable) |-> !ser_clk && !$past(ser_clk))
		else $error("enable moved with clock high");
	a_data_hold: assert property (ser_clk && $past(ser_clk) |-> $stable(ser_in))
		else $error("data moved with clock high");
	a_addr_count: assert property ($rose(xfer_enable) |-> rises == 6'd8)
		else $error("address not eight bits");
	a_addr_code: assert property ($rose(xfer_enable) |-> addr_sh inside {8'h28, 8'h29, 8'h2a})
		else $error("unknown address sent");
	a_word_bits: assert property ($fell(xfer_enable) && mode != 8'h2a |-> rises == 6'd24)
		else $error("write frame not 24 bits");
	a_read_stable: assert property (xfer_enable && mode == 8'h2a && ser_clk && $past(ser_clk)
		|-> $stable(ser_out_oe_n))
		else $error("read bit moved with clock high");
	c_write_a: cover property ($fell(xfer_enable) && mode == 8'h28);
	c_write_b: cover property ($fell(xfer_enable) && mode == 8'h29);
	c_read_low: cover property (xfer_enable && mode == 8'h2a && !ser_out_line);
endmodule

/* File: tb/tuner_pll_serial_control_tb.sv */
// Bench: AXI4-Lite orders to the controller, device pins observed.
// Assumes pull-ups on the serial output line and both two-way pins.
`timescale 1ns/1ns
module tuner_pll_serial_control_tb
	import ptsc_pkg::*;
;
	logic core_clk = 1'b0;
	logic reset_n = 1'b0;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [3:0] awaddr = 4'h0, araddr = 4'h0;
	logic [31:0] wdata = 32'h0;
	logic awready, wready, bvalid, arready, rvalid, pump_o, pump_oe_n, prev;
	logic [1:0] bresp, rresp, bidir_oe_n, pins;
	logic [31:0] rdata, r, d;
	logic hf = 1'b0, osc_run = 1'b0, rd_chk = 1'b0;
	logic vhf = 1'b0, vhf_run = 1'b0;
	logic [3:0] wstrb = 4'hf;
	logic [1:0] ext_pin = 2'h3;
	logic [3:0] od_oe_n;
	logic [7:0] mux_exp = 8'hed;
	logic [33:0] exp_q[$];
	int mismatches = 0, num_checks = 0, cycles = 0, i, t;
	ptsc_link_if link();
	assign pins = ext_pin & bidir_oe_n;
	ptsc_controller #(.SER_HALF_CYCLES(20)) u_ptsc_controller (.core_clk(core_clk),
		.reset_n(reset_n), .link(link), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_awaddr(awaddr), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata),
		.s_axi_wstrb(wstrb), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_araddr(araddr),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp));
	ptsc_device #(.TB_HALF_CYCLES(20), .GATE_BASE_CYCLES(16), .REF_CYCLES(48)) u_ptsc_device (
		.core_clk(core_clk), .reset_n(reset_n), .link(link), .vhf_osc_input(vhf),
		.hf_osc_input(hf), .if_input(hf), .bidir_in(pins), .bidir_out(), .bidir_oe_n(bidir_oe_n),
		.od_oe_n(od_oe_n), .pump_out_o(pump_o), .pump_out_oe_n(pump_oe_n));
	ptsc_link_properties u_ptsc_link_properties (.core_clk(core_clk), .reset_n(reset_n),
		.ser_clk(link.ser_clk), .xfer_enable(link.xfer_enable), .ser_in(link.ser_in),
		.ser_out_oe_n(link.ser_out_oe_n), .ser_out_line(link.ser_out_line));
	always #5 core_clk = ~core_clk;
	always @(posedge core_clk) hf <= osc_run && !hf;
	always @(posedge core_clk) vhf <= vhf_run && !vhf;
	task automatic summarize();
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic cmp(input logic [33:0] got, input logic [33:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			mismatches++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic axi_wr(input logic [3:0] a, input logic [31:0] v, input logic [1:0] e);
		exp_q.push_back({e, 32'h0});
		awaddr <= a;
		wdata <= v;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do
		begin
			@(posedge core_clk);
			awvalid <= awvalid && !awready;
			wvalid <= wvalid && !wready;
		end
		while (!bvalid);
		bready <= 1'b0;
		@(posedge core_clk);
	endtask
	task automatic axi_rd(input logic [3:0] a, input logic c, input logic [33:0] e,
		output logic [31:0] v);
		rd_chk <= c;
		if (c)
			exp_q.push_back(e);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do
		begin
			@(posedge core_clk);
			arvalid <= arvalid && !arready;
		end
		while (!rvalid);
		v = rdata;
		rready <= 1'b0;
		@(posedge core_clk);
	endtask
	// One link transfer, then wait for busy to clear
	task automatic frame(input logic [1:0] kind, input logic [23:0] word, input logic [4:0] n);
		int k;
		axi_wr(REG_WDATA, {8'h0, word}, RESP_OKAY);
		axi_wr(REG_CMD, {19'h0, n, 6'h0, kind}, RESP_OKAY);
		k = 0;
		do
		begin
			axi_rd(REG_STATUS, 1'b0, 34'h0, d);
			k++;
		end
		while (d[0] !== 1'b0 && k < 1000);
		cmp(d[0], 1'b0);
		repeat (8) @(posedge core_clk);
	endtask
	always @(posedge core_clk)
	begin
		if (bvalid && bready)
			cmp({bresp, 32'h0}, exp_q.pop_front());
		if (rvalid && rready && rd_chk)
			cmp({rresp, rdata}, exp_q.pop_front());
	end
	always @(posedge core_clk)
	begin
		cycles++;
		if (cycles == 60000)
		begin
			mismatches++;
			summarize();
		end
	end
	initial
	begin
		void'($urandom(32'h8c56fa0b));
		repeat (10) @(posedge core_clk);
		reset_n <= 1'b1;
		repeat (3) @(posedge core_clk);
		cmp(od_oe_n, 4'hf);
		cmp(bidir_oe_n, 2'h3);
		cmp({pump_oe_n, link.ser_out_line}, 2'h3);
		axi_rd(4'h2, 1'b1, {RESP_SLVERR, 32'h0}, d);
		axi_wr(REG_RDATA, 32'h1, RESP_SLVERR);
		axi_wr(REG_WDATA, 32'h00aabbcc, RESP_OKAY);
		wstrb <= 4'h2;
		axi_wr(REG_WDATA, 32'h00112233, RESP_OKAY);
		wstrb <= 4'hf;
		axi_rd(REG_WDATA, 1'b1, {RESP_OKAY, 32'h00aa22cc}, d);
		$display("test reset and registers done");
		for (i = 0; i < 3; i++)
		begin
			r = $urandom;
			frame(KIND_WRITE_B, {16'h0, r[7:2], 2'b11}, 5'd0);
			cmp(od_oe_n ^ r[5:2], 4'hf);
			cmp(bidir_oe_n ^ r[7:6], 2'h3);
		end
		$display("test output ports done");
		ext_pin <= 2'b10;
		for (i = 0; i < 8; i++)
		begin
			frame(KIND_WRITE_B, {13'h0, i[2:0], 8'h0}, 5'd0);
			cmp(link.ser_out_line, mux_exp[i]);
		end
		cmp(bidir_oe_n, 2'h3);
		$display("test output select done");
		frame(KIND_WRITE_B, 24'h000043, 5'd0);
		ext_pin <= 2'b11;
		frame(KIND_READ, 24'h0, 5'd2);
		axi_rd(REG_RDATA, 1'b1, {RESP_OKAY, 32'h2}, d);
		frame(KIND_WRITE_B, 24'h0, 5'd0);
		ext_pin <= 2'b01;
		frame(KIND_READ, 24'h0, 5'd23);
		axi_rd(REG_RDATA, 1'b1, {RESP_OKAY, 32'h00200000}, d);
		$display("test read frames done");
		osc_run <= 1'b1;
		frame(KIND_WRITE_A, 24'h000040, 5'd0);
		repeat (200) @(posedge core_clk);
		cmp({pump_oe_n, pump_o}, 2'h1);
		frame(KIND_WRITE_A, 24'h010018, 5'd0);
		repeat (300) @(posedge core_clk);
		cmp({pump_oe_n, pump_o}, 2'h2);
		frame(KIND_WRITE_A, 24'h02000c, 5'd0);
		repeat (200) @(posedge core_clk);
		cmp({pump_oe_n, pump_o}, 2'h0);
		vhf_run <= 1'b1;
		repeat (300) @(posedge core_clk);
		cmp({pump_oe_n, pump_o}, 2'h2);
		$display("test divider done");
		frame(KIND_WRITE_A, 24'h040040, 5'd0);
		frame(KIND_WRITE_B, 24'h001a00, 5'd0);
		repeat (100) @(posedge core_clk);
		cmp(link.ser_out_line, 1'b0);
		frame(KIND_READ, 24'h0, 5'd23);
		axi_rd(REG_RDATA, 1'b1, {RESP_OKAY, 32'h00200010}, d);
		t = 0;
		prev = od_oe_n[0];
		for (i = 0; i < 400; i++)
		begin
			@(posedge core_clk);
			t += int'(od_oe_n[0] !== prev);
			prev = od_oe_n[0];
		end
		cmp(t >= 19 && t <= 21, 1'b1);
		$display("test timebase and gate done");
		summarize();
	end
endmodule
